// ---- shared/vcr_pkg.sv ----
// constants for the channel resource 0 capability/control register bank
package vcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [11:0] VCR_CAP_OFF = 12'h210;
    localparam logic [11:0] VCR_CTL_OFF = 12'h214;
    localparam logic [11:0] VCR_STS_OFF = 12'h218;
    localparam logic [11:0] VCR_TBL_OFF = 12'h220;

    ////////////////////////////////////////////////////////////////////////////
    // capability register fields
    localparam int          VCR_CAP_ARB_LSB    = 0;
    localparam int          VCR_CAP_MAX_TIME_SLOTS_LSB  = 16;
    localparam int          VCR_CAP_TBLOFF_LSB = 24;
    localparam logic [7:0]  VCR_ARB_CAP_UP     = 8'h03;
    localparam logic [7:0]  VCR_ARB_CAP_DN     = 8'h01;
    localparam logic [6:0]  VCR_MAX_TIME_SLOTS_VAL      = 7'h00;
    localparam logic [7:0]  VCR_TBLOFF_UP      = 8'h02;
    localparam logic [7:0]  VCR_TBLOFF_DN      = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int          VCR_CTL_TCMAP_LSB  = 0;
    localparam int          VCR_CTL_LOAD_BIT   = 16;
    localparam int          VCR_CTL_SEL_LSB    = 17;
    localparam int          VCR_CTL_CHID_LSB   = 24;
    localparam int          VCR_CTL_EN_BIT     = 31;
    localparam logic [7:0]  VCR_TCMAP_RST      = 8'hff;
    localparam logic [7:0]  VCR_TCMAP_RO_MASK  = 8'h01;
    localparam logic [2:0]  VCR_SEL_RST        = 3'h0;
    localparam logic [2:0]  VCR_CHID_VAL       = 3'h0;
    localparam logic        VCR_EN_VAL         = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // arbitration select values and capability bit positions
    localparam logic [2:0]  VCR_SEL_FRR        = 3'h0;
    localparam logic [2:0]  VCR_SEL_WRR32      = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // status register and arbitration table
    localparam int          VCR_STS_TBL_BIT    = 0;
    localparam int          VCR_TBL_WORDS      = 4;
    localparam logic [31:0] VCR_TBL_RST        = 32'h1765_4321;

    ////////////////////////////////////////////////////////////////////////////
    // table load sequencer states, gray along idle -> copy -> done
    typedef enum logic [1:0]
    {
        VCR_LD_IDLE = 2'b00,
        VCR_LD_COPY = 2'b01,
        VCR_LD_DONE = 2'b11
    } vcr_ld_state_t;

endpackage

// ---- shared/vcr_load_if.sv ----
// handshake between the register bank and the table load sequencer
`timescale 1ns/1ps
interface vcr_load_if #(parameter int IDX_W = 2);
    logic             start;
    logic             copy;
    logic [IDX_W-1:0] idx;
    logic             done;
    logic             busy;

    modport ctl
    (
        output start,
        input  copy,
        input  idx,
        input  done,
        input  busy
    );

    modport seq
    (
        input  start,
        output copy,
        output idx,
        output done,
        output busy
    );
endinterface

// ---- core/vcr_table_load.sv ----
// sequencer that walks the arbitration table one word per clock
`timescale 1ns/1ps
module vcr_table_load
    import vcr_pkg::*;
#(
    parameter int TBL_WORDS = VCR_TBL_WORDS,
    parameter int IDX_W     = 2
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // link to the register bank
    vcr_load_if.seq   ld
);

    vcr_ld_state_t    state_q;
    vcr_ld_state_t    state_d;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    wire              last_word = (idx_q == IDX_W'(TBL_WORDS - 1));

    ////////////////////////////////////////////////////////////////////////////
    // a new trigger restarts the walk so the latest table contents win
    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        case (state_q)
            VCR_LD_IDLE:
            begin
                idx_d = '0;
            end
            VCR_LD_COPY:
            begin
                idx_d = idx_q + IDX_W'(1);
                if (last_word)
                begin
                    state_d = VCR_LD_DONE;
                end
            end
            VCR_LD_DONE:
            begin
                state_d = VCR_LD_IDLE;
            end
            default:
            begin
                state_d = VCR_LD_IDLE;
            end
        endcase
        if (ld.start)
        begin
            state_d = VCR_LD_COPY;
            idx_d   = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= VCR_LD_IDLE;
            idx_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    assign ld.copy = (state_q == VCR_LD_COPY);
    assign ld.idx  = idx_q;
    assign ld.done = (state_q == VCR_LD_DONE);
    assign ld.busy = (state_q != VCR_LD_IDLE);

endmodule

// ---- core/vcr_regs.sv ----
// channel resource 0 capability, control, status and arbitration table registers
`timescale 1ns/1ps
module vcr_regs
    import vcr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1,
    parameter int ADDR_W      = 12,
    parameter int TBL_WORDS   = VCR_TBL_WORDS
)
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_b_i,
    // register port
    input  wire logic [ADDR_W-1:0]         addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [31:0]               rdata_o,
    // towards the port arbiter
    output logic      [7:0]                traffic_class_map_o,
    output logic      [2:0]                arb_select_o,
    output logic      [32*TBL_WORDS-1:0]   arb_table_o,
    output logic                           arb_table_status_o,
    output logic                           load_busy_o
);

    localparam int IDX_W = (TBL_WORDS > 1) ? $clog2(TBL_WORDS) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // fixed capability values for this port flavour

    wire [7:0] arb_capability = IS_UPSTREAM ? VCR_ARB_CAP_UP : VCR_ARB_CAP_DN;
    wire [7:0] arb_table_offset = IS_UPSTREAM ? VCR_TBLOFF_UP : VCR_TBLOFF_DN;
    wire [6:0] max_time_slots = VCR_MAX_TIME_SLOTS_VAL;
    wire       has_table = IS_UPSTREAM;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire              word_aligned = (addr_i[1:0] == 2'b00);
    wire              hit_cap      = (addr_i == ADDR_W'(VCR_CAP_OFF));
    wire              hit_ctl      = (addr_i == ADDR_W'(VCR_CTL_OFF));
    wire              hit_sts      = (addr_i == ADDR_W'(VCR_STS_OFF));
    wire [ADDR_W-1:0] tbl_rel      = addr_i - ADDR_W'(VCR_TBL_OFF);
    wire              tbl_range    = (addr_i >= ADDR_W'(VCR_TBL_OFF)) &&
                                     (tbl_rel < ADDR_W'(TBL_WORDS * 4));
    wire              hit_tbl      = has_table && word_aligned && tbl_range;
    wire [IDX_W-1:0]  tbl_idx      = tbl_rel[IDX_W+1:2];

    wire              wr_ctl       = wr_i && hit_ctl;
    wire              wr_tbl       = wr_i && hit_tbl;

    ////////////////////////////////////////////////////////////////////////////
    // control register state

    logic [7:0] tc_map_q;
    logic [7:0] tc_map_d;
    logic [2:0] arb_sel_q;
    logic [2:0] arb_sel_d;

    // the read-only low bit keeps its reset value whatever is written
    assign tc_map_d = wr_ctl
        ? ((wdata_i[VCR_CTL_TCMAP_LSB +: 8] & ~VCR_TCMAP_RO_MASK) |
           (tc_map_q & VCR_TCMAP_RO_MASK))
        : tc_map_q;

    assign arb_sel_d = wr_ctl ? wdata_i[VCR_CTL_SEL_LSB +: 3] : arb_sel_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tc_map_q  <= VCR_TCMAP_RST;
            arb_sel_q <= VCR_SEL_RST;
        end
        else
        begin
            tc_map_q  <= tc_map_d;
            arb_sel_q <= arb_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load trigger qualification
    // the scheme is judged on the select value already held, not the one
    // arriving in the same write, so set the select first, then trigger.
    // an unsupported select value (software's fault) never triggers a load.

    wire sel_in_cap   = (arb_sel_q == VCR_SEL_WRR32) && arb_capability[VCR_SEL_WRR32];
    wire sel_uses_tbl = sel_in_cap;
    wire load_req     = wr_ctl && wdata_i[VCR_CTL_LOAD_BIT];
    wire load_go      = load_req && IS_UPSTREAM && sel_uses_tbl;

    ////////////////////////////////////////////////////////////////////////////
    // load sequencer

    vcr_load_if #(.IDX_W(IDX_W)) ld ();

    assign ld.start = load_go;

    vcr_table_load #(
        .TBL_WORDS (TBL_WORDS),
        .IDX_W     (IDX_W)
    ) u_load (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ld      (ld.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // software-visible table and the copy the arbiter runs from
    // the arbiter keeps the old table until the walk reaches each word,
    // so a half-written table in software view never disturbs arbitration.

    logic [31:0] tbl_q [TBL_WORDS];
    logic [31:0] act_q [TBL_WORDS];

    for (genvar w = 0; w < TBL_WORDS; w++)
    begin : g_tbl
        wire wr_this   = wr_tbl && (tbl_idx == IDX_W'(w));
        wire copy_this = ld.copy && (ld.idx == IDX_W'(w));

        always_ff @(posedge clk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
            begin
                tbl_q[w] <= VCR_TBL_RST;
            end
            else if (wr_this)
            begin
                tbl_q[w] <= wdata_i;
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
            begin
                act_q[w] <= VCR_TBL_RST;
            end
            else if (copy_this)
            begin
                act_q[w] <= tbl_q[w];
            end
        end

        assign arb_table_o[32*w +: 32] = act_q[w];
    end

    ////////////////////////////////////////////////////////////////////////////
    // table status: a table write during the closing cycle wins over the clear

    logic tbl_sts_q;
    logic tbl_sts_d;

    always_comb
    begin
        tbl_sts_d = tbl_sts_q;
        if (ld.done)
        begin
            tbl_sts_d = 1'b0;
        end
        if (wr_tbl)
        begin
            tbl_sts_d = 1'b1;
        end
        if (!has_table)
        begin
            tbl_sts_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tbl_sts_q <= 1'b0;
        end
        else
        begin
            tbl_sts_q <= tbl_sts_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register images; every bit not assigned here is reserved and reads zero

    logic [31:0] cap_img;
    logic [31:0] ctl_img;
    logic [31:0] sts_img;

    always_comb
    begin
        cap_img = 32'h0000_0000;
        cap_img[VCR_CAP_ARB_LSB +: 8]    = arb_capability;
        cap_img[VCR_CAP_MAX_TIME_SLOTS_LSB +: 7]  = max_time_slots;
        cap_img[VCR_CAP_TBLOFF_LSB +: 8] = arb_table_offset;
    end

    always_comb
    begin
        ctl_img = 32'h0000_0000;
        ctl_img[VCR_CTL_TCMAP_LSB +: 8] = tc_map_q;
        ctl_img[VCR_CTL_LOAD_BIT]       = 1'b0;
        ctl_img[VCR_CTL_SEL_LSB +: 3]   = arb_sel_q;
        ctl_img[VCR_CTL_CHID_LSB +: 3]  = VCR_CHID_VAL;
        ctl_img[VCR_CTL_EN_BIT]         = VCR_EN_VAL;
    end

    always_comb
    begin
        sts_img = 32'h0000_0000;
        sts_img[VCR_STS_TBL_BIT] = tbl_sts_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped and unaligned addresses read zero

    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_cap)
        begin
            rd_mux = cap_img;
        end
        else if (hit_ctl)
        begin
            rd_mux = ctl_img;
        end
        else if (hit_sts)
        begin
            rd_mux = sts_img;
        end
        else if (hit_tbl)
        begin
            rd_mux = tbl_q[tbl_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data stand for exactly the cycle after the read strobe

    logic [31:0] rdata_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_i)
        begin
            rdata_q <= rd_mux;
        end
        else
        begin
            rdata_q <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata_o             = rdata_q;
    assign traffic_class_map_o = tc_map_q;
    assign arb_select_o        = arb_sel_q;
    assign arb_table_status_o  = tbl_sts_q;
    assign load_busy_o         = ld.busy;

endmodule

// ---- tb/vcr_regs_props.sv ----
// concurrent checks on the channel resource register bank ports
`timescale 1ns/1ps
module vcr_regs_props
    import vcr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1,
    parameter int ADDR_W      = 12,
    parameter int TBL_WORDS   = VCR_TBL_WORDS
)
(
    // clock, reset and register port
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic [ADDR_W-1:0]       addr_i,
    input wire logic [31:0]             wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire logic [31:0]             rdata_o,
    // arbiter side
    input wire logic [7:0]              traffic_class_map_o,
    input wire logic [2:0]              arb_select_o,
    input wire logic [32*TBL_WORDS-1:0] arb_table_o,
    input wire logic                    arb_table_status_o,
    input wire logic                    load_busy_o
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////
    logic [31:0] wd_q;
    wire         ctl_hit = (addr_i == VCR_CTL_OFF);
    wire         tbl_hit = IS_UPSTREAM && (addr_i[1:0] == 2'b00) && (addr_i >= VCR_TBL_OFF)
                           && (addr_i < VCR_TBL_OFF + 12'(4 * TBL_WORDS));
    wire         mapped  = (addr_i == VCR_CAP_OFF) || ctl_hit || (addr_i == VCR_STS_OFF) || tbl_hit;
    wire         trig    = wr_i && ctl_hit && wdata_i[16] && (arb_select_o == 3'h1);
    wire  [31:0] cap_w   = IS_UPSTREAM ? 32'h0200_0003 : 32'h0000_0001;

    always_ff @(posedge clk_i)
    begin
        wd_q <= wdata_i;
    end

    sequence ctl_read;
        rd_i && ctl_hit;
    endsequence
    // a load walks five busy cycles: four copies and a done beat
    sequence copy_run;
        load_busy_o[*5] ##1 !load_busy_o;
    endsequence

    cap_word_a: assert property (rd_i && addr_i == VCR_CAP_OFF |=> rdata_o == cap_w)
        else $error("capability word wrong");
    ctl_fixed_a: assert property (ctl_read |=> (rdata_o & 32'hfff1_ff01) == 32'h8000_0001)
        else $error("control fixed bits wrong");
    ctl_live_a: assert property (ctl_read |=> rdata_o[7:0] == $past(traffic_class_map_o)
        && rdata_o[19:17] == $past(arb_select_o)) else $error("control readback wrong");
    ctl_write_a: assert property (wr_i && ctl_hit |=> traffic_class_map_o == (wd_q[7:0] | 8'h01)
        && arb_select_o == wd_q[19:17]) else $error("control write not stored");
    unmapped_zero_a: assert property (rd_i && !mapped |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    load_start_a: assert property (trig && !load_busy_o |=> load_busy_o == IS_UPSTREAM)
        else $error("load did not start");
    no_load_a: assert property (!trig && !load_busy_o |=> !load_busy_o)
        else $error("load started without trigger");
    copy_len_a: assert property ($rose(load_busy_o) |-> copy_run)
        else $error("load length wrong");
    status_set_a: assert property (wr_i && tbl_hit |=> arb_table_status_o)
        else $error("table status not set");
    // a table write in the closing cycle keeps the status set, so it is excused
    status_clear_a: assert property ($fell(load_busy_o) && !$past(wr_i && tbl_hit) |-> !arb_table_status_o)
        else $error("table status not cleared");
    down_quiet_a: assert property (!IS_UPSTREAM |-> !load_busy_o && !arb_table_status_o)
        else $error("downstream load activity");
endmodule

bind vcr_regs vcr_regs_props #(.IS_UPSTREAM(IS_UPSTREAM), .ADDR_W(ADDR_W), .TBL_WORDS(TBL_WORDS))
    props_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .traffic_class_map_o(traffic_class_map_o),
    .arb_select_o(arb_select_o), .arb_table_o(arb_table_o),
    .arb_table_status_o(arb_table_status_o), .load_busy_o(load_busy_o));

// ---- tb/tb_vcr_regs.sv ----
// self-checking bench for the channel resource register bank, both port flavours
`timescale 1ns/1ps
module tb_vcr_regs
    import vcr_pkg::*;
;
    logic         clk_i, rst_b_i, wr_i, rd_i;
    logic [11:0]  addr_i;
    logic [31:0]  wdata_i, rdata_u, rdata_d, seed, w;
    logic [7:0]   map_u, map_d;
    logic [2:0]   sel_u, sel_d;
    logic [127:0] tbl_u, tbl_d;
    logic         sts_u, sts_d, busy_u, busy_d;
    logic [31:0]  tw [4];
    logic [11:0]  bad [3] = '{12'h21c, 12'h215, 12'h3fc};
    logic [31:0]  nold [3] = '{32'h0002_0000, 32'h0000_0000, 32'h0001_0000};
    int           fail_count, check_count, cyc, i, n;

    // both flavours share one register bus; each answers on its own read data
    vcr_regs #(.IS_UPSTREAM(1'b1)) dut_u
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_u), .traffic_class_map_o(map_u),
        .arb_select_o(sel_u), .arb_table_o(tbl_u), .arb_table_status_o(sts_u),
        .load_busy_o(busy_u)
    );
    vcr_regs #(.IS_UPSTREAM(1'b0)) dut_dn
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_d), .traffic_class_map_o(map_d),
        .arb_select_o(sel_d), .arb_table_o(tbl_d), .arb_table_status_o(sts_d),
        .load_busy_o(busy_d)
    );

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ctl_exp(input logic [7:0] m, input logic [2:0] s);
        return {1'b1, 11'h000, s, 1'b0, 8'h00, m | 8'h01};
    endfunction
    // wide enough for busy, status and the whole active table side by side
    task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask
    // read data is looked at just after the edge that follows the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        {rst_b_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        seed = 32'h0000_2f6b;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wr(VCR_CAP_OFF, 32'hffff_ffff);
        rd(VCR_CAP_OFF);
        chk({rdata_u, rdata_d}, {32'h0200_0003, 32'h0000_0001});
        rd(VCR_CTL_OFF);
        chk({rdata_u, rdata_d}, {2{32'h8000_00ff}});
        chk({sel_u, map_u, tbl_u}, {3'h0, 8'hff, {4{VCR_TBL_RST}}});
        rd(VCR_TBL_OFF);
        chk({rdata_u, rdata_d}, {VCR_TBL_RST, 32'h0});
        $display("end of test: reset values");
        for (i = 0; i < 26; i++)
        begin
            w = (i == 0) ? 32'h0 : (i == 1) ? 32'hfffe_ffff : xs() & 32'hfffe_ffff;
            w[19:17] = 3'(i);
            wr(VCR_CTL_OFF, w);
            rd(VCR_CTL_OFF);
            chk({rdata_u, rdata_d}, {2{ctl_exp(w[7:0], w[19:17])}});
            chk({busy_u, sel_u, map_u}, {1'b0, w[19:17], w[7:0] | 8'h01});
            chk({sel_d, map_d}, {w[19:17], w[7:0] | 8'h01});
        end
        for (i = 0; i < 3; i++)
        begin
            wr(bad[i], xs());
            rd(bad[i]);
            chk({rdata_u, rdata_d}, 64'h0);
        end
        rd(VCR_CTL_OFF);
        chk(rdata_u, ctl_exp(w[7:0], w[19:17]));
        $display("end of test: control fields");
        wr(VCR_CTL_OFF, 32'h0002_0000);
        for (i = 0; i < 4; i++)
        begin
            tw[i] = xs();
            wr(VCR_TBL_OFF + 12'(4 * i), tw[i]);
        end
        chk({sts_u, sts_d, tbl_u}, {2'b10, {4{VCR_TBL_RST}}});
        wr(VCR_CTL_OFF, 32'h0003_0000);
        chk({busy_u, busy_d}, 2'b10);
        for (n = 0; n < 12 && busy_u !== 1'b0; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk({sts_u, sts_d, tbl_u}, {2'b00, tw[3], tw[2], tw[1], tw[0]});
        chk(tbl_d, {4{VCR_TBL_RST}});
        rd(VCR_CTL_OFF);
        chk(rdata_u, ctl_exp(8'h00, 3'h1));
        $display("end of test: table load");
        wr(VCR_TBL_OFF + 12'h4, ~tw[1]);
        for (i = 0; i < 3; i++)
        begin
            wr(VCR_CTL_OFF, nold[i]);
            chk({busy_u, sts_u, tbl_u}, {2'b01, tw[3], tw[2], tw[1], tw[0]});
        end
        rd(VCR_TBL_OFF + 12'h4);
        chk({rdata_u, rdata_d}, {~tw[1], 32'h0});
        $display("end of test: load refused");
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(VCR_CTL_OFF);
        chk({rdata_u, sts_u, tbl_u}, {32'h8000_00ff, 1'b0, {4{VCR_TBL_RST}}});
        $display("end of test: second reset");
        tally_and_finish();
    end
endmodule
